// file: verilog/enb_sa_loop_ctrl.sv
// Our own choice: the strobed register port.
`timescale 1ns/10ps
// How it works
// - Select bit 7 low: Sa8 from backplane serial; high: from Sa8 register.
// - Select bit 6 low: Sa7 from backplane serial; high: from Sa7 register.
// - Select bit 5 low: Sa6 from backplane serial; high: from Sa6 register.
// - Select bit 4 low: Sa5 from backplane serial; high: from Sa5 register.
// - Select bit 3 low: Sa4 from backplane serial; high: from Sa4 register.
// - Enable one: Sa5 zeros, Sa6 ones, A ones, eight words each, loops.
// - Enable two: Sa5 zeros, Sa6 alternating, A ones, eight words, loops.
// - Release enable: Sa5 and Sa6 zeros for eight words ends loopback.
// - Auto loop control acts only while Sa5 and Sa6 come from serial.
// - Select and auto loop enable bits reset to zero.
module enb_sa_loop_ctrl (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire enb_pkg::enb_timing_t timing_in,
  input wire logic backplane_tx_serial_in,
  input wire enb_pkg::enb_sa_vals_t sa_vals_in,
  input wire logic [enb_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rd_data_out,
  output logic tx_serial_out,
  output logic tx_valid_out,
  output logic local_loop_out,
  output logic defect_detect_en_out
);
  import enb_pkg::*;

  logic ser_meta_reg;
  logic ser_sync_reg;
  enb_timing_t tim_d1_reg;
  enb_timing_t tim_d2_reg;
  logic [7:0] pos_reg;
  logic [2:0] nfas_cnt_reg;
  logic [7:0] sel_reg;
  logic [7:0] ddet_reg;
  logic [7:0] rd_data_reg;
  logic tx_bit_reg;
  logic tx_valid_reg;
  enb_loop_state_t state_reg;
  enb_loop_state_t state_next;
  logic src_two_reg;
  logic src_two_next;

  // ----------------------------------------
  // Backplane input synchroniser, timing aligned
  // ----------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ser_meta_reg <= 1'b0;
      ser_sync_reg <= 1'b0;
      tim_d1_reg <= '0;
      tim_d2_reg <= '0;
    end
    else
    begin
      ser_meta_reg <= backplane_tx_serial_in;
      ser_sync_reg <= ser_meta_reg;
      tim_d1_reg <= timing_in;
      tim_d2_reg <= tim_d1_reg;
    end
  end

  // ----------------------------------------
  // Bit position within frame
  // ----------------------------------------
  logic [7:0] bit_idx;
  logic bit_en;
  logic in_ts0_nfas;
  logic at_sa4;
  logic at_sa5;
  logic at_sa6;
  logic at_sa7;
  logic at_sa8;
  logic at_a;
  logic word_done;

  assign bit_en = tim_d2_reg.bit_en;
  assign bit_idx = tim_d2_reg.frame_start ? 8'h00 : pos_reg;
  assign in_ts0_nfas = bit_en && tim_d2_reg.nfas;
  assign at_a = in_ts0_nfas && (bit_idx == POS_A);
  assign at_sa4 = in_ts0_nfas && (bit_idx == POS_SA4);
  assign at_sa5 = in_ts0_nfas && (bit_idx == POS_SA5);
  assign at_sa6 = in_ts0_nfas && (bit_idx == POS_SA6);
  assign at_sa7 = in_ts0_nfas && (bit_idx == POS_SA8 - 8'h01);
  assign at_sa8 = in_ts0_nfas && (bit_idx == POS_SA8);
  assign word_done = at_sa8 && (nfas_cnt_reg == 3'h7);

  // Position and non-alignment frame counters
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pos_reg <= 8'h00;
      nfas_cnt_reg <= 3'h0;
    end
    else
    begin
      if (bit_en)
        pos_reg <= bit_idx + 8'h01;
      if (at_sa8)
        nfas_cnt_reg <= nfas_cnt_reg + 3'h1;
    end
  end

  // ----------------------------------------
  // National bit source selection
  // ----------------------------------------
  logic [2:0] reg_bit_idx;
  logic [4:0] sa_reg_bit;
  logic out_bit;

  // Register bits sent most significant first over eight frames
  assign reg_bit_idx = 3'h7 - nfas_cnt_reg;
  assign sa_reg_bit[0] = sa_vals_in.sa4[reg_bit_idx];
  assign sa_reg_bit[1] = sa_vals_in.sa5[reg_bit_idx];
  assign sa_reg_bit[2] = sa_vals_in.sa6[reg_bit_idx];
  assign sa_reg_bit[3] = sa_vals_in.sa7[reg_bit_idx];
  assign sa_reg_bit[4] = sa_vals_in.sa8[reg_bit_idx];
  assign out_bit = (at_sa8 && sel_reg[BIT_SA8_SEL]) ? sa_reg_bit[4] :
    (at_sa7 && sel_reg[BIT_SA7_SEL]) ? sa_reg_bit[3] :
    (at_sa6 && sel_reg[BIT_SA6_SEL]) ? sa_reg_bit[2] :
    (at_sa5 && sel_reg[BIT_SA5_SEL]) ? sa_reg_bit[1] :
    (at_sa4 && sel_reg[BIT_SA4_SEL]) ? sa_reg_bit[0] :
    ser_sync_reg;

  // Transmit bit register
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tx_bit_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
    end
    else
    begin
      tx_valid_reg <= bit_en;
      if (bit_en)
        tx_bit_reg <= out_bit;
    end
  end

  // ----------------------------------------
  // Pattern detectors on backplane bits
  // ----------------------------------------
  logic hit_sa5_zero;
  logic hit_sa6_ones;
  logic hit_sa6_alt;
  logic hit_sa6_zero;
  logic hit_a_ones;

  enb_pattern_det #(.PATTERN(PAT_ZERO), .REPEAT(REPEAT_CNT)) u_sa5_zero (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .shift_in(at_sa5),
    .bit_in(ser_sync_reg), .word_done_in(word_done), .hit_out(hit_sa5_zero));
  enb_pattern_det #(.PATTERN(PAT_ONES), .REPEAT(REPEAT_CNT)) u_sa6_ones (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .shift_in(at_sa6),
    .bit_in(ser_sync_reg), .word_done_in(word_done), .hit_out(hit_sa6_ones));
  enb_pattern_det #(.PATTERN(PAT_ALT), .REPEAT(REPEAT_CNT)) u_sa6_alt (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .shift_in(at_sa6),
    .bit_in(ser_sync_reg), .word_done_in(word_done), .hit_out(hit_sa6_alt));
  enb_pattern_det #(.PATTERN(PAT_ZERO), .REPEAT(REPEAT_CNT)) u_sa6_zero (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .shift_in(at_sa6),
    .bit_in(ser_sync_reg), .word_done_in(word_done), .hit_out(hit_sa6_zero));
  enb_pattern_det #(.PATTERN(PAT_ONES), .REPEAT(REPEAT_CNT)) u_a_ones (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .shift_in(at_a),
    .bit_in(ser_sync_reg), .word_done_in(word_done), .hit_out(hit_a_ones));

  // ----------------------------------------
  // Automatic loopback control
  // ----------------------------------------
  logic from_serial;
  logic act_one;
  logic act_two;
  logic release_hit;
  logic src_en_kept;

  assign from_serial = !sel_reg[BIT_SA5_SEL] && !sel_reg[BIT_SA6_SEL];
  assign act_one = sel_reg[BIT_LOOP1_EN] && from_serial && hit_sa5_zero
    && hit_sa6_ones && hit_a_ones;
  assign act_two = sel_reg[BIT_LOOP2_EN] && from_serial && hit_sa5_zero
    && hit_sa6_alt && hit_a_ones;
  assign release_hit = sel_reg[BIT_RELEASE_EN] && from_serial && hit_sa5_zero
    && hit_sa6_zero;
  assign src_en_kept = src_two_reg ? sel_reg[BIT_LOOP2_EN] : sel_reg[BIT_LOOP1_EN];

  // Loopback state transitions
  always_comb
  begin
    state_next = state_reg;
    src_two_next = src_two_reg;
    case (state_reg)
      LOOP_OFF:
      begin
        if (act_one || act_two)
        begin
          state_next = LOOP_ON;
          src_two_next = !act_one;
        end
      end
      LOOP_ON:
      begin
        if (release_hit || !src_en_kept)
          state_next = LOOP_OFF;
      end
      default:
      begin
        state_next = LOOP_OFF;
        src_two_next = 1'b0;
      end
    endcase
  end

  // Loopback state register
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= LOOP_OFF;
      src_two_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      src_two_reg <= src_two_next;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic wr_sel;
  logic wr_ddet;
  logic [7:0] status_val;
  logic [7:0] rd_mux;

  assign wr_sel = wr_in && (addr_in == OFS_NAT_SEL);
  assign wr_ddet = wr_in && (addr_in == OFS_DEFECT_DET);
  assign status_val = {2'b00, hit_a_ones, hit_sa6_zero, hit_sa6_alt,
    hit_sa6_ones, src_two_reg, state_reg == LOOP_ON};
  assign rd_mux = (addr_in == OFS_NAT_SEL) ? sel_reg :
    (addr_in == OFS_DEFECT_DET) ? ddet_reg :
    (addr_in == OFS_LOOP_STATUS) ? status_val : 8'h00;

  // Writes and read data
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sel_reg <= RST_NAT_SEL;
      ddet_reg <= RST_DEFECT_DET;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      if (wr_sel)
        sel_reg <= wr_data_in;
      if (wr_ddet)
        ddet_reg <= {wr_data_in[BIT_DEFECT_DET], 7'h00};
      rd_data_reg <= rd_in ? rd_mux : 8'h00;
    end
  end

  assign rd_data_out = rd_data_reg;
  assign tx_serial_out = tx_bit_reg;
  assign tx_valid_out = tx_valid_reg;
  assign local_loop_out = (state_reg == LOOP_ON);
  assign defect_detect_en_out = ddet_reg[BIT_DEFECT_DET];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SA8_REG: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    at_sa8 && sel_reg[BIT_SA8_SEL] |=> tx_serial_out == $past(sa_reg_bit[4]))
    else $error("Sa8 not taken from register");
  AST_SA7_SER: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    at_sa7 && !sel_reg[BIT_SA7_SEL] |=> tx_serial_out == $past(ser_sync_reg))
    else $error("Sa7 not taken from serial input");
  AST_SA6_REG: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    at_sa6 && sel_reg[BIT_SA6_SEL] |=> tx_serial_out == $past(sa_reg_bit[2]))
    else $error("Sa6 not taken from register");
  AST_SA5_REG: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    at_sa5 && sel_reg[BIT_SA5_SEL] |=> tx_serial_out == $past(sa_reg_bit[1]))
    else $error("Sa5 not taken from register");
  AST_SA4_SER: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    at_sa4 && !sel_reg[BIT_SA4_SEL] |=> tx_serial_out == $past(ser_sync_reg))
    else $error("Sa4 not taken from serial input");
  AST_LOOP_ONE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !local_loop_out && act_one |=> local_loop_out && !src_two_reg)
    else $error("Loop one pattern did not activate loopback");
  AST_LOOP_TWO: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !local_loop_out && act_two && !act_one |=> local_loop_out && src_two_reg)
    else $error("Loop two pattern did not activate loopback");
  AST_RELEASE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    local_loop_out && release_hit |=> !local_loop_out)
    else $error("Release pattern did not end loopback");
  AST_SERIAL_ONLY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !local_loop_out && !from_serial |=> !local_loop_out)
    else $error("Loopback activated with Sa from registers");
  AST_RESET_VAL: assert property (@(posedge ref_clk_in)
    rst_in |=> sel_reg == 8'h00 && !local_loop_out)
    else $error("Select bits or loopback not cleared by reset");
  AST_LOOP_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    local_loop_out && !release_hit && src_en_kept |=> local_loop_out)
    else $error("Loopback dropped without cause");
  COV_LOOP_ONE: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(local_loop_out) && !src_two_reg);
  COV_LOOP_TWO: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(local_loop_out) && src_two_reg);
  COV_RELEASE: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    local_loop_out && release_hit ##1 !local_loop_out);

endmodule

// file: shared/enb_pkg.sv
package enb_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_LOOP_ACT_CODE = 12'h126;
  localparam logic [11:0] OFS_LOOP_DEACT_CODE = 12'h127;
  localparam logic [11:0] OFS_DEFECT_DET = 12'h129;
  localparam logic [11:0] OFS_NAT_SEL = 12'h130;
  localparam logic [11:0] OFS_LOOP_STATUS = 12'h138;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int BIT_SA8_SEL = 7;
  localparam int BIT_SA7_SEL = 6;
  localparam int BIT_SA6_SEL = 5;
  localparam int BIT_SA5_SEL = 4;
  localparam int BIT_SA4_SEL = 3;
  localparam int BIT_LOOP1_EN = 2;
  localparam int BIT_LOOP2_EN = 1;
  localparam int BIT_RELEASE_EN = 0;
  localparam int BIT_DEFECT_DET = 7;
  localparam logic [7:0] RST_NAT_SEL = 8'h00;
  localparam logic [7:0] RST_DEFECT_DET = 8'h80;

  // ----------------------------------------
  // Timeslot 0 bit positions in a non-alignment frame
  // ----------------------------------------
  localparam logic [7:0] POS_A = 8'h02;
  localparam logic [7:0] POS_SA4 = 8'h03;
  localparam logic [7:0] POS_SA5 = 8'h04;
  localparam logic [7:0] POS_SA6 = 8'h05;
  localparam logic [7:0] POS_SA8 = 8'h07;

  // ----------------------------------------
  // Loopback code patterns and repeat count
  // ----------------------------------------
  localparam logic [7:0] PAT_ZERO = 8'h00;
  localparam logic [7:0] PAT_ONES = 8'hff;
  localparam logic [7:0] PAT_ALT = 8'haa;
  localparam int REPEAT_CNT = 8;

  // Loopback state, one-hot
  typedef enum logic [1:0] {
    LOOP_OFF = 2'b01,
    LOOP_ON = 2'b10
  } enb_loop_state_t;

  // Frame timing from the transmit framer
  typedef struct packed {
    logic bit_en;
    logic frame_start;
    logic nfas;
  } enb_timing_t;

  // Sa4..Sa8 register values, one byte each
  typedef struct packed {
    logic [7:0] sa8;
    logic [7:0] sa7;
    logic [7:0] sa6;
    logic [7:0] sa5;
    logic [7:0] sa4;
  } enb_sa_vals_t;

endpackage

// file: verilog/enb_pattern_det.sv
`timescale 1ns/10ps
module enb_pattern_det #(
  parameter logic [7:0] PATTERN = 8'h00,
  parameter int REPEAT = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic shift_in,
  input wire logic bit_in,
  input wire logic word_done_in,
  output logic hit_out
);
  import enb_pkg::*;

  logic [7:0] word_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic match;
  logic full;

  // ----------------------------------------
  // Word compare and repeat counter
  // ----------------------------------------
  assign match = (word_reg == PATTERN);
  assign full = (cnt_reg == 4'(REPEAT));
  assign cnt_next = !match ? 4'h0 : (full ? cnt_reg : cnt_reg + 4'h1);
  assign hit_out = full;

  // Bit gathering and counting
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      word_reg <= 8'h00;
      cnt_reg <= 4'h0;
    end
    else
    begin
      if (shift_in)
        word_reg <= {word_reg[6:0], bit_in};
      if (word_done_in)
        cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_MISMATCH_CLEARS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    word_done_in && !match |=> cnt_reg == 4'h0)
    else $error("Count kept after a mismatching word");
  AST_MATCH_COUNTS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    word_done_in && match && !full |=> cnt_reg == $past(cnt_reg) + 4'h1)
    else $error("Matching word not counted");

endmodule

// file: verif/enb_backplane_model.sv
`timescale 1ns/10ps
module enb_backplane_model (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] a_pat_in,
  input wire logic [7:0] sa5_pat_in,
  input wire logic [7:0] sa6_pat_in,
  output enb_pkg::enb_timing_t timing_out,
  output logic serial_out
);
  import enb_pkg::*;
  logic phase_reg;
  logic [7:0] idx_reg;
  logic [2:0] k_reg;
  logic bit_val;

  // ----------------------------------------
  // Frame counters
  // ----------------------------------------
  // One bit each second clock; short 64-bit frames, all non-alignment, keep runs short
  localparam logic [7:0] LAST_IDX = 8'h3f;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      phase_reg <= 1'b0;
      idx_reg <= 8'h00;
      k_reg <= 3'h0;
    end
    else
    begin
      phase_reg <= ~phase_reg;
      if (phase_reg)
      begin
        if (idx_reg == LAST_IDX)
        begin
          idx_reg <= 8'h00;
          k_reg <= k_reg + 3'h1;
        end
        else
          idx_reg <= idx_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Serial data
  // ----------------------------------------
  // Pattern bytes MSB first, one bit per frame; inverse between strobes
  assign bit_val = (idx_reg == POS_A) ? a_pat_in[3'h7 - k_reg] :
    (idx_reg == POS_SA5) ? sa5_pat_in[3'h7 - k_reg] :
    (idx_reg == POS_SA6) ? sa6_pat_in[3'h7 - k_reg] : idx_reg[0] ^ idx_reg[3];
  assign serial_out = phase_reg ? bit_val : ~bit_val;
  assign timing_out = '{bit_en: phase_reg, frame_start: phase_reg && idx_reg == 8'h00,
    nfas: 1'b1};
endmodule

// file: verif/enb_sa_loop_ctrl_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e, m) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("BAD %0t %s got %h exp %h", $time, m, g, e); \
    end \
  end

module enb_sa_loop_ctrl_tb_top;
  import enb_pkg::*;
  logic ref_clk_in;
  logic rst_in;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic tx_serial, tx_valid, loop_on, defect_en, pin, exp_bit;
  enb_timing_t timing;
  logic [7:0] a_pat, sa5_pat, sa6_pat, sel_shadow;
  logic [7:0] sa_word [5] = '{8'hc3, 8'h18, 8'h24, 8'h42, 8'h81};
  logic exp_q [$];
  int miscompares = 0;
  int checked = 0;

  // ----------------------------------------
  // Clock, far side and design
  // ----------------------------------------
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  enb_backplane_model bp (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .a_pat_in(a_pat),
    .sa5_pat_in(sa5_pat), .sa6_pat_in(sa6_pat), .timing_out(timing), .serial_out(pin));

  enb_sa_loop_ctrl DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .timing_in(timing),
    .backplane_tx_serial_in(pin),
    .sa_vals_in({sa_word[4], sa_word[3], sa_word[2], sa_word[1], sa_word[0]}),
    .addr_in(addr), .wr_data_in(wdata), .wr_in(wr_en), .rd_in(rd_en),
    .rd_data_out(rd_data), .tx_serial_out(tx_serial), .tx_valid_out(tx_valid),
    .local_loop_out(loop_on), .defect_detect_en_out(defect_en));

  // ----------------------------------------
  // Transmit stream scoreboard
  // ----------------------------------------
  function automatic logic exp_of(input logic [7:0] pos, input logic [2:0] k, input logic p);
    if (pos >= POS_SA4 && pos <= POS_SA8 && sel_shadow[pos[2:0]])
      return sa_word[pos[2:0] - 3'h3][3'h7 - k];
    return p;
  endfunction

  // Queue each strobed bit, compare when the design presents it
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      exp_q.delete();
    else
    begin
      if (tx_valid === 1'b1)
      begin
        exp_bit = exp_q.pop_front();
        `CHK(tx_serial, exp_bit, "tx bit")
      end
      if (timing.bit_en)
      begin
        exp_q.push_back(exp_of(bp.idx_reg, bp.k_reg, pin));
        `CHK(exp_q.size() <= 2, 1'b1, "tx valid missing")
      end
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Writes kept clear of the national bit slots
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    while (bp.idx_reg < 8'd16 || bp.idx_reg > 8'd56)
      @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    if (a == OFS_NAT_SEL)
      sel_shadow <= d;
    @(posedge ref_clk_in);
    wr_en <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e, input string m);
    @(posedge ref_clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk_in);
    rd_en <= 1'b0;
    #1 `CHK(rd_data, e, m)
  endtask

  task automatic wait_frames(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in);
      while (!timing.frame_start)
        @(posedge ref_clk_in);
    end
  endtask

  // New patterns from the next word; loop must change on the 8th word only
  task automatic loop_step(input logic [7:0] s5, input logic [7:0] s6, input logic [7:0] sel,
    input logic want, input logic [7:0] st);
    while (!(bp.k_reg == 3'h7 && bp.idx_reg == 8'd32))
      @(posedge ref_clk_in);
    a_pat <= 8'hff;
    sa5_pat <= s5;
    sa6_pat <= s6;
    wr(OFS_NAT_SEL, sel);
    wait_frames(64);
    #1 `CHK(loop_on, ~want, "loop early")
    repeat (40) @(posedge ref_clk_in);
    #1 `CHK(loop_on, want, "loop late")
    chk_rd(OFS_LOOP_STATUS, st, "status");
  endtask

  task automatic end_test(input string n);
    $display("test %s done", n);
  endtask

  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    rst_in = 1'b1;
    addr = 12'h000;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    a_pat = 8'h5a;
    sa5_pat = 8'h3c;
    sa6_pat = 8'h96;
    sel_shadow = 8'h00;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    chk_rd(OFS_NAT_SEL, 8'h00, "select reset");
    chk_rd(OFS_DEFECT_DET, RST_DEFECT_DET, "defect reset");
    chk_rd(OFS_LOOP_STATUS, 8'h00, "status reset");
    chk_rd(OFS_LOOP_ACT_CODE, 8'h00, "reserved code");
    #1 `CHK(loop_on, 1'b0, "loop reset")
    wr(OFS_DEFECT_DET, 8'h00);
    chk_rd(OFS_DEFECT_DET, 8'h00, "defect clear");
    #1 `CHK(defect_en, 1'b0, "defect pin")
    wr(OFS_DEFECT_DET, 8'hff);
    chk_rd(OFS_DEFECT_DET, 8'h80, "defect set");
    #1 `CHK(defect_en, 1'b1, "defect pin")
    wr(OFS_LOOP_DEACT_CODE, 8'hff);
    chk_rd(OFS_LOOP_DEACT_CODE, 8'h00, "reserved write");
    wr(12'h3ff, 8'h55);
    chk_rd(12'h3ff, 8'h00, "unmapped");
    wr(OFS_NAT_SEL, 8'hf8);
    chk_rd(OFS_NAT_SEL, 8'hf8, "select rw");
    wait_frames(9);
    end_test("registers");
    loop_step(8'h00, 8'hff, 8'hcd, 1'b1, 8'h25);
    end_test("loop one");
    loop_step(8'h00, 8'h00, 8'hcd, 1'b0, 8'h30);
    end_test("release");
    loop_step(8'h00, 8'haa, 8'h02, 1'b1, 8'h2b);
    wr(OFS_NAT_SEL, 8'h30);
    repeat (4) @(posedge ref_clk_in);
    #1 `CHK(loop_on, 1'b0, "enable cleared")
    wr(OFS_NAT_SEL, 8'h32);
    wait_frames(9);
    #1 `CHK(loop_on, 1'b0, "from register")
    wr(OFS_NAT_SEL, 8'h02);
    repeat (40) @(posedge ref_clk_in);
    #1 `CHK(loop_on, 1'b1, "re-enabled")
    end_test("loop two");
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    sel_shadow <= 8'h00;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    chk_rd(OFS_NAT_SEL, 8'h00, "select rereset");
    #1 `CHK(loop_on, 1'b0, "loop rereset")
    `CHK(defect_en, 1'b1, "defect rereset")
    end_test("second reset");
    wrap_up();
  end

  // Watchdog: three 64-frame phases of 128 clocks, whole run about 111 us
  initial
  begin
    #300us;
    miscompares++;
    wrap_up();
  end
endmodule
